// ---- logic/sppm_pin_cell.sv ----
module sppm_pin_cell #(
   parameter int NF = 4,
   parameter int SW = 2
) (
   // Selection
   input  wire logic [SW-1:0] sel_i,
   // Function side
   input  wire logic [NF-1:0] func_out_i,
   input  wire logic [NF-1:0] func_oe_i,
   output logic      [NF-1:0] func_in_o,
   // Pad side
   input  wire logic          pad_in_i,
   output logic               pad_out_o,
   output logic               pad_oe_o
);

   // Unselected functions see a steady low rather than pad noise
   always_comb begin
      pad_out_o        = func_out_i[sel_i];
      pad_oe_o         = func_oe_i[sel_i];
      func_in_o        = '0;
      func_in_o[sel_i] = pad_in_i;
   end

endmodule // sppm_pin_cell

// ---- logic/sppm_pkg.sv ----
package sppm_pkg;

   // ----------------------------------------------------------------
   // Pad map
   // ----------------------------------------------------------------
   localparam int PAD_N   = 39;
   localparam int PAD_SPI = 0;   // Dedicated SPI clk, rx, tx, cs0..cs3
   localparam int PAD_DG  = 7;   // Dedicated GPIO 12..17
   localparam int PAD_SH  = 13;  // Shared parallel-group pins
   localparam int PAD_S1  = 21;  // Serial group one
   localparam int PAD_S0  = 27;  // Serial group zero
   localparam int PAD_AD  = 33;  // External address / GPIO pins
   localparam int N_SPI   = 7;
   localparam int N_DG    = 6;
   localparam int N_SH    = 8;
   localparam int N_SER   = 6;
   localparam int N_I2S   = 4;
   localparam int N_AD    = 6;
   localparam int N_GPIO  = 32;

   // GPIO numbers per pin position
   localparam int GPIO_DG  = 12;
   localparam int GPIO_S1  = 6;
   localparam int GPIO_S0  = 0;
   localparam int GPIO_AD  = 21;
   localparam int SH_GPIO [N_SH] = '{18, 19, 20, 27, 28, 29, 30, 31};
   localparam int SH_SPI  [N_I2S] = '{0, 3, 1, 2};

   // ----------------------------------------------------------------
   // Function slots of a pad cell
   // ----------------------------------------------------------------
   localparam int          SLOT_N    = 4;
   localparam int          SLOT_W    = 2;
   localparam logic [1:0]  SLOT_NONE = 2'h0;
   localparam logic [1:0]  SLOT_A    = 2'h1;
   localparam logic [1:0]  SLOT_B    = 2'h2;
   localparam logic [1:0]  SLOT_C    = 2'h3;

   // ----------------------------------------------------------------
   // Selection register layout
   // ----------------------------------------------------------------
   localparam int          ESR_W     = 16;
   localparam int          AD_LSB    = 0;
   localparam int          SP0_LSB   = 8;
   localparam int          SP1_LSB   = 10;
   localparam int          PP_LSB    = 12;
   localparam logic [15:0] ESR_WMASK = 16'h7F3F;
   localparam logic [15:0] ESR_RST   = 16'h1000;

   localparam logic [2:0] PP_M0 = 3'h0;
   localparam logic [2:0] PP_M1 = 3'h1;
   localparam logic [2:0] PP_M2 = 3'h2;
   localparam logic [2:0] PP_M3 = 3'h3;
   localparam logic [2:0] PP_M4 = 3'h4;
   localparam logic [2:0] PP_M5 = 3'h5;
   localparam logic [2:0] PP_M6 = 3'h6;
   localparam logic [1:0] SP_MMC  = 2'h0;
   localparam logic [1:0] SP_I2S  = 2'h1;
   localparam logic [1:0] SP_GPIO = 2'h2;
   localparam logic [1:0] SP_BAD  = 2'h3;

   // ----------------------------------------------------------------
   // Pulldown inhibit layouts
   // ----------------------------------------------------------------
   localparam int          PD1_W      = 12;
   localparam int          PD1_S0_LSB = 0;
   localparam int          PD1_S1_LSB = 6;
   localparam logic [11:0] PD1_RST    = 12'h000;
   localparam int          PD3_W      = 16;
   localparam int          PD3_DG_LSB = 2;
   localparam int          PD3_SH_LSB = 8;
   localparam logic [15:0] PD3_WMASK  = 16'hFFFC;
   localparam logic [15:0] PD3_RST    = 16'h0000;

   typedef struct packed {
      logic [ESR_W-1:0]   esr;
      logic [PD1_W-1:0]   pd1;
      logic [PD3_W-1:0]   pd3;
      logic [PAD_N-1:0]   pad_out;
      logic [PAD_N-1:0]   pad_oe;
      logic [PAD_N-1:0]   pad_pd;
      logic [N_SPI-1:0]   spi_in;
      logic [N_I2S-1:0]   uart_in;
      logic [N_I2S-1:0]   i2s0_in;
      logic [N_I2S-1:0]   i2s1_in;
      logic [N_I2S-1:0]   i2s2_in;
      logic [N_I2S-1:0]   i2s3_in;
      logic [N_SER-1:0]   mmc0_in;
      logic [N_SER-1:0]   mmc1_in;
      logic [N_GPIO-1:0]  gpio_in;
      logic               mode_bad;
   } sppm_state_t;

endpackage

// ---- logic/sppm_top.sv ----
// Functional notes
// - Parallel modes 001/110: dedicated SPI pins are SPI, dedicated pins GPIO 12-17.
// - Modes 010-101 idle dedicated pins; shared pins follow the mode table.
// - Third inhibit bits control shared-pin pulldowns regardless of selected function.
// - Serial one: 00 MMC1; 01 audio port one plus GPIO 10, 11.
// - Serial one mode 10 makes all six pins GPIO 6-11.
// - Serial zero: 00 MMC0; 01 audio port zero plus GPIO 4, 5.
// - Serial zero mode 10 makes all six pins GPIO 0-5.
// - First inhibit register holds twelve pulldown bits for both serial groups.
// - Address-mode bit 0 selects address line 15-20, 1 selects GPIO 21-26.
// - One selection register holds every mux control field.
module sppm_top (
   // Clock and reset
   input  wire logic                           ref_clk_i,
   input  wire logic                           sys_rst_i,
   // Configuration writes and readback
   input  wire logic                           esr_wr_i,
   input  wire logic [sppm_pkg::ESR_W-1:0]     esr_wdata_i,
   input  wire logic                           pd1_wr_i,
   input  wire logic [sppm_pkg::PD1_W-1:0]     pd1_wdata_i,
   input  wire logic                           pd3_wr_i,
   input  wire logic [sppm_pkg::PD3_W-1:0]     pd3_wdata_i,
   output logic      [sppm_pkg::ESR_W-1:0]     esr_rdata_o,
   output logic      [sppm_pkg::PD1_W-1:0]     pd1_rdata_o,
   output logic      [sppm_pkg::PD3_W-1:0]     pd3_rdata_o,
   output logic                                mode_bad_o,
   // Pads
   input  wire logic [sppm_pkg::PAD_N-1:0]     pad_in_i,
   output logic      [sppm_pkg::PAD_N-1:0]     pad_out_o,
   output logic      [sppm_pkg::PAD_N-1:0]     pad_oe_o,
   output logic      [sppm_pkg::PAD_N-1:0]     pad_pd_en_o,
   // SPI
   input  wire logic [sppm_pkg::N_SPI-1:0]     spi_out_i,
   input  wire logic [sppm_pkg::N_SPI-1:0]     spi_oe_i,
   output logic      [sppm_pkg::N_SPI-1:0]     spi_in_o,
   // UART
   input  wire logic [sppm_pkg::N_I2S-1:0]     uart_out_i,
   input  wire logic [sppm_pkg::N_I2S-1:0]     uart_oe_i,
   output logic      [sppm_pkg::N_I2S-1:0]     uart_in_o,
   // Audio serial ports
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s0_out_i,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s0_oe_i,
   output logic      [sppm_pkg::N_I2S-1:0]     i2s0_in_o,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s1_out_i,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s1_oe_i,
   output logic      [sppm_pkg::N_I2S-1:0]     i2s1_in_o,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s2_out_i,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s2_oe_i,
   output logic      [sppm_pkg::N_I2S-1:0]     i2s2_in_o,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s3_out_i,
   input  wire logic [sppm_pkg::N_I2S-1:0]     i2s3_oe_i,
   output logic      [sppm_pkg::N_I2S-1:0]     i2s3_in_o,
   // MMC/SD ports
   input  wire logic [sppm_pkg::N_SER-1:0]     mmc0_out_i,
   input  wire logic [sppm_pkg::N_SER-1:0]     mmc0_oe_i,
   output logic      [sppm_pkg::N_SER-1:0]     mmc0_in_o,
   input  wire logic [sppm_pkg::N_SER-1:0]     mmc1_out_i,
   input  wire logic [sppm_pkg::N_SER-1:0]     mmc1_oe_i,
   output logic      [sppm_pkg::N_SER-1:0]     mmc1_in_o,
   // External memory address lines 15..20
   input  wire logic [sppm_pkg::N_AD-1:0]      ext_addr_i,
   input  wire logic [sppm_pkg::N_AD-1:0]      ext_addr_oe_i,
   // GPIO
   input  wire logic [sppm_pkg::N_GPIO-1:0]    gpio_out_i,
   input  wire logic [sppm_pkg::N_GPIO-1:0]    gpio_oe_i,
   output logic      [sppm_pkg::N_GPIO-1:0]    gpio_in_o
);
   import sppm_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   sppm_state_t        st_r;
   sppm_state_t        st_nxt;

   logic [SLOT_N-1:0]  c_out [PAD_N];
   logic [SLOT_N-1:0]  c_oe  [PAD_N];
   logic [SLOT_W-1:0]  c_sel [PAD_N];
   logic [SLOT_N-1:0]  fin   [PAD_N];
   logic [PAD_N-1:0]   p_out;
   logic [PAD_N-1:0]   p_oe;

   logic [2:0]         pp_mode;
   logic [1:0]         sp1_mode;
   logic [1:0]         sp0_mode;
   logic [N_AD-1:0]    ad_mode;
   logic [SLOT_W-1:0]  sel_ded;
   logic [SLOT_W-1:0]  sel_lo;
   logic [SLOT_W-1:0]  sel_hi;

   assign pp_mode  = st_r.esr[PP_LSB +: 3];
   assign sp1_mode = st_r.esr[SP1_LSB +: 2];
   assign sp0_mode = st_r.esr[SP0_LSB +: 2];
   assign ad_mode  = st_r.esr[AD_LSB +: N_AD];

   // ----------------------------------------------------------------
   // Mode decode and candidate functions per pad
   // ----------------------------------------------------------------
   always_comb begin
      // Mode 000 and 111 fall to no function: pins float
      sel_ded = SLOT_NONE;
      sel_lo  = SLOT_NONE;
      sel_hi  = SLOT_NONE;
      case (pp_mode)
         PP_M1: begin
            sel_ded = SLOT_A;
            sel_lo  = SLOT_A;
            sel_hi  = SLOT_A;
         end
         PP_M2: begin
            sel_lo = SLOT_B;
            sel_hi = SLOT_B;
         end
         PP_M3: begin
            sel_lo = SLOT_C;
            sel_hi = SLOT_C;
         end
         PP_M4: begin
            sel_lo = SLOT_A;
            sel_hi = SLOT_A;
         end
         PP_M5: begin
            sel_lo = SLOT_C;
            sel_hi = SLOT_A;
         end
         PP_M6: begin
            sel_ded = SLOT_A;
            sel_lo  = SLOT_A;
            sel_hi  = SLOT_C;
         end
         default: begin
            sel_ded = SLOT_NONE;
         end
      endcase

      for (int p = 0; p < PAD_N; p++) begin
         c_out[p] = '0;
         c_oe[p]  = '0;
         c_sel[p] = SLOT_NONE;
      end
      for (int k = 0; k < N_SPI; k++) begin
         c_out[PAD_SPI+k][SLOT_A] = spi_out_i[k];
         c_oe[PAD_SPI+k][SLOT_A]  = spi_oe_i[k];
         c_sel[PAD_SPI+k]         = sel_ded;
      end
      for (int k = 0; k < N_DG; k++) begin
         c_out[PAD_DG+k][SLOT_A] = gpio_out_i[GPIO_DG+k];
         c_oe[PAD_DG+k][SLOT_A]  = gpio_oe_i[GPIO_DG+k];
         c_sel[PAD_DG+k]         = sel_ded;
      end
      for (int k = 0; k < N_SH; k++) begin
         c_out[PAD_SH+k][SLOT_B] = gpio_out_i[SH_GPIO[k]];
         c_oe[PAD_SH+k][SLOT_B]  = gpio_oe_i[SH_GPIO[k]];
         if (k < N_I2S) begin
            c_out[PAD_SH+k][SLOT_A] = i2s2_out_i[k];
            c_oe[PAD_SH+k][SLOT_A]  = i2s2_oe_i[k];
            c_out[PAD_SH+k][SLOT_C] = spi_out_i[SH_SPI[k]];
            c_oe[PAD_SH+k][SLOT_C]  = spi_oe_i[SH_SPI[k]];
            c_sel[PAD_SH+k]         = sel_lo;
         end else begin
            c_out[PAD_SH+k][SLOT_A] = uart_out_i[k-N_I2S];
            c_oe[PAD_SH+k][SLOT_A]  = uart_oe_i[k-N_I2S];
            c_out[PAD_SH+k][SLOT_C] = i2s3_out_i[k-N_I2S];
            c_oe[PAD_SH+k][SLOT_C]  = i2s3_oe_i[k-N_I2S];
            c_sel[PAD_SH+k]         = sel_hi;
         end
      end
      for (int k = 0; k < N_SER; k++) begin
         c_out[PAD_S1+k][SLOT_A] = mmc1_out_i[k];
         c_oe[PAD_S1+k][SLOT_A]  = mmc1_oe_i[k];
         c_out[PAD_S1+k][SLOT_C] = gpio_out_i[GPIO_S1+k];
         c_oe[PAD_S1+k][SLOT_C]  = gpio_oe_i[GPIO_S1+k];
         c_out[PAD_S0+k][SLOT_A] = mmc0_out_i[k];
         c_oe[PAD_S0+k][SLOT_A]  = mmc0_oe_i[k];
         c_out[PAD_S0+k][SLOT_C] = gpio_out_i[GPIO_S0+k];
         c_oe[PAD_S0+k][SLOT_C]  = gpio_oe_i[GPIO_S0+k];
         if (k < N_I2S) begin
            c_out[PAD_S1+k][SLOT_B] = i2s1_out_i[k];
            c_oe[PAD_S1+k][SLOT_B]  = i2s1_oe_i[k];
            c_out[PAD_S0+k][SLOT_B] = i2s0_out_i[k];
            c_oe[PAD_S0+k][SLOT_B]  = i2s0_oe_i[k];
         end
         case (sp1_mode)
            SP_MMC:  c_sel[PAD_S1+k] = SLOT_A;
            SP_I2S:  c_sel[PAD_S1+k] = (k < N_I2S) ? SLOT_B : SLOT_C;
            SP_GPIO: c_sel[PAD_S1+k] = SLOT_C;
            default: c_sel[PAD_S1+k] = SLOT_NONE;
         endcase
         case (sp0_mode)
            SP_MMC:  c_sel[PAD_S0+k] = SLOT_A;
            SP_I2S:  c_sel[PAD_S0+k] = (k < N_I2S) ? SLOT_B : SLOT_C;
            SP_GPIO: c_sel[PAD_S0+k] = SLOT_C;
            default: c_sel[PAD_S0+k] = SLOT_NONE;
         endcase
      end
      for (int k = 0; k < N_AD; k++) begin
         c_out[PAD_AD+k][SLOT_A] = ext_addr_i[k];
         c_oe[PAD_AD+k][SLOT_A]  = ext_addr_oe_i[k];
         c_out[PAD_AD+k][SLOT_B] = gpio_out_i[GPIO_AD+k];
         c_oe[PAD_AD+k][SLOT_B]  = gpio_oe_i[GPIO_AD+k];
         c_sel[PAD_AD+k]         = ad_mode[k] ? SLOT_B : SLOT_A;
      end
   end

   // ----------------------------------------------------------------
   // Pad cells
   // ----------------------------------------------------------------
   for (genvar g = 0; g < PAD_N; g++) begin : g_pad
      sppm_pin_cell #(
         .NF (SLOT_N),
         .SW (SLOT_W)
      ) u_cell (
         .sel_i      (c_sel[g]),
         .func_out_i (c_out[g]),
         .func_oe_i  (c_oe[g]),
         .func_in_o  (fin[g]),
         .pad_in_i   (pad_in_i[g]),
         .pad_out_o  (p_out[g]),
         .pad_oe_o   (p_oe[g])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Reserved bits are never stored, so they read back as zero
      if (esr_wr_i) begin
         st_nxt.esr = esr_wdata_i & ESR_WMASK;
      end
      if (pd1_wr_i) begin
         st_nxt.pd1 = pd1_wdata_i;
      end
      if (pd3_wr_i) begin
         st_nxt.pd3 = pd3_wdata_i & PD3_WMASK;
      end
      st_nxt.mode_bad = (pp_mode == PP_M0) || (pp_mode > PP_M6) ||
                        (sp1_mode == SP_BAD) || (sp0_mode == SP_BAD);

      st_nxt.pad_out = p_out;
      st_nxt.pad_oe  = p_oe;
      st_nxt.pad_pd  = '0;
      for (int k = 0; k < N_DG; k++) begin
         st_nxt.pad_pd[PAD_DG+k] = ~st_r.pd3[PD3_DG_LSB+k];
      end
      for (int k = 0; k < N_SH; k++) begin
         st_nxt.pad_pd[PAD_SH+k] = ~st_r.pd3[PD3_SH_LSB+k];
      end
      for (int k = 0; k < N_SER; k++) begin
         st_nxt.pad_pd[PAD_S0+k] = ~st_r.pd1[PD1_S0_LSB+k];
         st_nxt.pad_pd[PAD_S1+k] = ~st_r.pd1[PD1_S1_LSB+k];
      end

      // Inputs: a signal that can land on two pads is the OR of both,
      // only one of which is ever selected
      st_nxt.spi_in  = '0;
      st_nxt.uart_in = '0;
      st_nxt.i2s0_in = '0;
      st_nxt.i2s1_in = '0;
      st_nxt.i2s2_in = '0;
      st_nxt.i2s3_in = '0;
      st_nxt.mmc0_in = '0;
      st_nxt.mmc1_in = '0;
      st_nxt.gpio_in = '0;
      for (int k = 0; k < N_SPI; k++) begin
         st_nxt.spi_in[k] = fin[PAD_SPI+k][SLOT_A];
      end
      for (int k = 0; k < N_DG; k++) begin
         st_nxt.gpio_in[GPIO_DG+k] = fin[PAD_DG+k][SLOT_A];
      end
      for (int k = 0; k < N_SH; k++) begin
         st_nxt.gpio_in[SH_GPIO[k]] = fin[PAD_SH+k][SLOT_B];
         if (k < N_I2S) begin
            st_nxt.i2s2_in[k]         = fin[PAD_SH+k][SLOT_A];
            st_nxt.spi_in[SH_SPI[k]] = st_nxt.spi_in[SH_SPI[k]] | fin[PAD_SH+k][SLOT_C];
         end else begin
            st_nxt.uart_in[k-N_I2S] = fin[PAD_SH+k][SLOT_A];
            st_nxt.i2s3_in[k-N_I2S] = fin[PAD_SH+k][SLOT_C];
         end
      end
      for (int k = 0; k < N_SER; k++) begin
         st_nxt.mmc1_in[k]         = fin[PAD_S1+k][SLOT_A];
         st_nxt.mmc0_in[k]         = fin[PAD_S0+k][SLOT_A];
         st_nxt.gpio_in[GPIO_S1+k] = fin[PAD_S1+k][SLOT_C];
         st_nxt.gpio_in[GPIO_S0+k] = fin[PAD_S0+k][SLOT_C];
         if (k < N_I2S) begin
            st_nxt.i2s1_in[k] = fin[PAD_S1+k][SLOT_B];
            st_nxt.i2s0_in[k] = fin[PAD_S0+k][SLOT_B];
         end
      end
      for (int k = 0; k < N_AD; k++) begin
         st_nxt.gpio_in[GPIO_AD+k] = fin[PAD_AD+k][SLOT_B];
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r     <= '0;
         st_r.esr <= ESR_RST;
         st_r.pd1 <= PD1_RST;
         st_r.pd3 <= PD3_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign esr_rdata_o = st_r.esr;
   assign pd1_rdata_o = st_r.pd1;
   assign pd3_rdata_o = st_r.pd3;
   assign mode_bad_o  = st_r.mode_bad;
   assign pad_out_o   = st_r.pad_out;
   assign pad_oe_o    = st_r.pad_oe;
   assign pad_pd_en_o = st_r.pad_pd;
   assign spi_in_o    = st_r.spi_in;
   assign uart_in_o   = st_r.uart_in;
   assign i2s0_in_o   = st_r.i2s0_in;
   assign i2s1_in_o   = st_r.i2s1_in;
   assign i2s2_in_o   = st_r.i2s2_in;
   assign i2s3_in_o   = st_r.i2s3_in;
   assign mmc0_in_o   = st_r.mmc0_in;
   assign mmc1_in_o   = st_r.mmc1_in;
   assign gpio_in_o   = st_r.gpio_in;

endmodule // sppm_top

// ---- testbench/sppm_board.sv ----
module sppm_board (
   // Clock
   input  wire logic                       ref_clk_i,
   // Device side of each pad
   input  wire logic [sppm_pkg::PAD_N-1:0] dev_out_i,
   input  wire logic [sppm_pkg::PAD_N-1:0] dev_oe_i,
   input  wire logic [sppm_pkg::PAD_N-1:0] dev_pd_i,
   // Board drivers and resulting level
   input  wire logic [sppm_pkg::PAD_N-1:0] drv_i,
   input  wire logic [sppm_pkg::PAD_N-1:0] drv_en_i,
   output logic      [sppm_pkg::PAD_N-1:0] lvl_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sppm_pkg::*;

   // Unheld pads toggle so stale levels never pass
   logic [PAD_N-1:0] last_r = '0;

   always_comb begin
      for (int p = 0; p < PAD_N; p++) begin
         if (dev_oe_i[p]) lvl_o[p] = dev_out_i[p];
         else if (drv_en_i[p]) lvl_o[p] = drv_i[p];
         else if (dev_pd_i[p]) lvl_o[p] = 1'b0;
         else lvl_o[p] = ~last_r[p];
      end
   end

   always @(posedge ref_clk_i) last_r <= lvl_o;
endmodule // sppm_board

// ---- testbench/sppm_checker.sv ----
module sppm_checker (
   // Config
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        esr_wr_i,
   input wire logic [15:0] esr_wdata_i,
   input wire logic        pd1_wr_i,
   input wire logic [11:0] pd1_wdata_i,
   input wire logic        pd3_wr_i,
   input wire logic [15:0] pd3_wdata_i,
   input wire logic [15:0] esr_rdata_o,
   input wire logic [11:0] pd1_rdata_o,
   input wire logic [15:0] pd3_rdata_o,
   input wire logic        mode_bad_o,
   // Pads
   input wire logic [38:0] pad_in_i,
   input wire logic [38:0] pad_out_o,
   input wire logic [38:0] pad_oe_o,
   input wire logic [38:0] pad_pd_en_o,
   input wire logic [5:0]  mmc1_out_i,
   input wire logic [5:0]  mmc1_oe_i,
   input wire logic [5:0]  ext_addr_i,
   input wire logic [5:0]  ext_addr_oe_i,
   input wire logic [31:0] gpio_out_i,
   input wire logic [31:0] gpio_oe_i,
   input wire logic [31:0] gpio_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sppm_pkg::*;

   // Pads lag reset release by one edge
   logic up_r;
   logic bad_now;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) up_r <= 1'b0;
      else up_r <= 1'b1;
   end
   assign bad_now = esr_rdata_o[14:12] inside {PP_M0, 3'h7} || esr_rdata_o[11:10] == SP_BAD
                    || esr_rdata_o[9:8] == SP_BAD;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s0_gpio_set;
      esr_wr_i && esr_wdata_i[9:8] == SP_GPIO ##1 !esr_wr_i;
   endsequence

   esr_store_a: assert property (
      esr_wr_i |=> esr_rdata_o == ($past(esr_wdata_i) & ESR_WMASK)) else $error("esr store");
   pd1_store_a: assert property (
      pd1_wr_i |=> pd1_rdata_o == $past(pd1_wdata_i)) else $error("pd1 store");
   pd3_store_a: assert property (
      pd3_wr_i |=> pd3_rdata_o == ($past(pd3_wdata_i) & PD3_WMASK)) else $error("pd3 store");
   esr_hold_a: assert property (
      !esr_wr_i |=> $stable(esr_rdata_o)) else $error("esr drift");
   bad_flag_a: assert property (
      up_r |-> mode_bad_o == $past(bad_now)) else $error("mode flag");
   serial_pd_a: assert property (
      up_r |-> pad_pd_en_o[32:21] == ~{$past(pd1_rdata_o[5:0]), $past(pd1_rdata_o[11:6])})
      else $error("serial pd");
   parallel_pd_a: assert property (
      up_r |-> pad_pd_en_o[20:7] == ~$past(pd3_rdata_o[15:2]) && pad_pd_en_o[6:0] == 7'h00)
      else $error("parallel pd");
   addr_gpio_a: assert property (
      up_r && $past(esr_rdata_o[0]) |-> pad_out_o[33] == $past(gpio_out_i[21])
      && pad_oe_o[33] == $past(gpio_oe_i[21])) else $error("addr gpio");
   addr_line_a: assert property (
      up_r && !$past(esr_rdata_o[5]) |-> pad_out_o[38] == $past(ext_addr_i[5])
      && pad_oe_o[38] == $past(ext_addr_oe_i[5])) else $error("addr line");
   s0_gpio_in_a: assert property (
      s0_gpio_set |=> ##1 gpio_in_o[5:0] == $past(pad_in_i[32:27])) else $error("gpio in");
   s1_float_a: assert property (
      up_r && $past(esr_rdata_o[11:10]) == SP_BAD |-> pad_oe_o[26:21] == 6'h00)
      else $error("serial float");
   mmc1_route_a: assert property (
      up_r && $past(esr_rdata_o[11:10]) == SP_MMC |-> pad_out_o[26:21] == $past(mmc1_out_i)
      && pad_oe_o[26:21] == $past(mmc1_oe_i)) else $error("mmc1 route");
   ded_idle_a: assert property (
      up_r && $past(esr_rdata_o[14:12]) inside {[3'h2:3'h5]} |-> pad_oe_o[12:0] == 13'h0000)
      else $error("ded driven");
endmodule // sppm_checker

// ---- testbench/tb_serial_port_pin_multiplexer.sv ----
module tb_serial_port_pin_multiplexer;
   timeunit 1ns;
   timeprecision 1ps;
   import sppm_pkg::*;

   logic             ref_clk_i;
   logic             sys_rst_i;
   logic             esr_wr_i, pd1_wr_i, pd3_wr_i, mode_bad_o;
   logic [15:0]      esr_wdata_i, esr_rdata_o, esr_m, e;
   logic [11:0]      pd1_wdata_i, pd1_rdata_o, pd1_m;
   logic [15:0]      pd3_wdata_i, pd3_rdata_o, pd3_m;
   logic [PAD_N-1:0] pad_in_i, pad_out_o, pad_oe_o, pad_pd_en_o, drv, drv_en;
   // Function slots: 1 spi 2 uart 3..6 audio 7..8 mmc 9 address 10 gpio
   logic [31:0]      po [11];
   logic [31:0]      pe [11];
   logic [31:0]      sin [11];
   int               fails = 0, n_compared = 0;

   sppm_top sppm_top_i (.*,
      .spi_out_i(po[1][6:0]), .spi_oe_i(pe[1][6:0]), .spi_in_o(sin[1][6:0]),
      .uart_out_i(po[2][3:0]), .uart_oe_i(pe[2][3:0]), .uart_in_o(sin[2][3:0]),
      .i2s0_out_i(po[3][3:0]), .i2s0_oe_i(pe[3][3:0]), .i2s0_in_o(sin[3][3:0]),
      .i2s1_out_i(po[4][3:0]), .i2s1_oe_i(pe[4][3:0]), .i2s1_in_o(sin[4][3:0]),
      .i2s2_out_i(po[5][3:0]), .i2s2_oe_i(pe[5][3:0]), .i2s2_in_o(sin[5][3:0]),
      .i2s3_out_i(po[6][3:0]), .i2s3_oe_i(pe[6][3:0]), .i2s3_in_o(sin[6][3:0]),
      .mmc0_out_i(po[7][5:0]), .mmc0_oe_i(pe[7][5:0]), .mmc0_in_o(sin[7][5:0]),
      .mmc1_out_i(po[8][5:0]), .mmc1_oe_i(pe[8][5:0]), .mmc1_in_o(sin[8][5:0]),
      .ext_addr_i(po[9][5:0]), .ext_addr_oe_i(pe[9][5:0]),
      .gpio_out_i(po[10]), .gpio_oe_i(pe[10]), .gpio_in_o(sin[10]));

   sppm_board sppm_board_i (.ref_clk_i, .dev_out_i(pad_out_o), .dev_oe_i(pad_oe_o),
      .dev_pd_i(pad_pd_en_o), .drv_i(drv), .drv_en_i(drv_en), .lvl_o(pad_in_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   // ----------------------------------------
   // Reference model: slot*64 + index per pad
   // ----------------------------------------
   function automatic int fmap(int p, logic [15:0] r);
      int k;
      int md;
      k = (p < 21) ? p - 13 : (p < 27) ? p - 21 : (p < 33) ? p - 27 : p - 33;
      md = r[14:12];
      if (p < 13) begin
         if (md != 1 && md != 6) return 0;
         return (p < 7) ? 64 + p : 645 + p;
      end
      if (p < 21) begin
         case (md)
            1, 4: return (k < 4) ? 320 + k : 124 + k;
            2: return 640 + SH_GPIO[k];
            3: return (k < 4) ? 64 + SH_SPI[k] : 380 + k;
            5: return (k < 4) ? 64 + SH_SPI[k] : 124 + k;
            6: return (k < 4) ? 320 + k : 380 + k;
            default: return 0;
         endcase
      end
      if (p < 33) begin
         md = (p < 27) ? r[11:10] : r[9:8];
         if (md == 0) return (p < 27) ? 512 + k : 448 + k;
         if (md == 1 && k < 4) return (p < 27) ? 256 + k : 192 + k;
         if (md == 3) return 0;
         return (p < 27) ? 646 + k : 640 + k;
      end
      return r[p - 33] ? 661 + k : 576 + k;
   endfunction

   task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic verify();
      logic [PAD_N-1:0] eo, ee, ep;
      logic [31:0]      ein [11];
      logic [31:0]      edc [11];
      logic [31:0]      msk;
      logic             lv;
      int               m, f, x;
      ein = '{default: '0};
      edc = '{default: '0};
      for (int p = 0; p < PAD_N; p++) begin
         m = fmap(p, esr_m);
         f = m / 64;
         x = m % 64;
         eo[p] = po[f][x];
         ee[p] = pe[f][x];
         ep[p] = (p < 7 || p > 32) ? 1'b0 : (p < 21) ? !pd3_m[p - 5]
                 : !pd1_m[(p < 27) ? p - 15 : p - 27];
         lv = ee[p] ? eo[p] : drv_en[p] ? drv[p] : 1'b0;
         if (!ee[p] && !drv_en[p] && !ep[p]) edc[f][x] = 1'b1;
         else ein[f][x] = ein[f][x] | lv;
      end
      check("pad_out", 64'(pad_out_o), 64'(eo));
      check("pad_oe", 64'(pad_oe_o), 64'(ee));
      check("pad_pd_en", 64'(pad_pd_en_o), 64'(ep));
      check("mode_bad", 64'(mode_bad_o), 64'(esr_m[14:12] inside {3'h0, 3'h7}
            || esr_m[11:10] == 2'h3 || esr_m[9:8] == 2'h3));
      for (int g = 1; g < 11; g++) begin
         msk = 32'((64'h1 << (g == 1 ? 7 : g < 7 ? 4 : g < 9 ? 6 : 32)) - 1);
         if (g != 9) check("func_in", 64'((sin[g] | edc[g]) & msk), 64'((ein[g] | edc[g]) & msk));
      end
   endtask

   task automatic shake();
      for (int f = 1; f < 11; f++) begin
         po[f] = $urandom();
         pe[f] = $urandom();
      end
      drv = 39'({$urandom(), $urandom()});
      drv_en = 39'({$urandom(), $urandom()} | {$urandom(), $urandom()});
   endtask

   task automatic settle();
      repeat (4) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wr_cfg(logic [15:0] r, logic [11:0] a, logic [15:0] b, bit hold);
      {esr_wr_i, pd1_wr_i, pd3_wr_i} = 3'h7;
      esr_wdata_i = r;
      pd1_wdata_i = a;
      pd3_wdata_i = b;
      @(posedge ref_clk_i);
      #1;
      if (!hold) {esr_wr_i, pd1_wr_i, pd3_wr_i} = 3'h0;
      {esr_m, pd1_m, pd3_m} = {r & ESR_WMASK, a, b & PD3_WMASK};
      check("esr_rdata", 64'(esr_rdata_o), 64'(esr_m));
      check("pd1_rdata", 64'(pd1_rdata_o), 64'(pd1_m));
      check("pd3_rdata", 64'(pd3_rdata_o), 64'(pd3_m));
   endtask

   task automatic reset_check();
      check("esr_rst", 64'(esr_rdata_o), 64'(ESR_RST));
      check("pd_rst", 64'({pd1_rdata_o, pd3_rdata_o}), 64'({PD1_RST, PD3_RST}));
      check("oe_rst", 64'(pad_oe_o), 64'h0);
      sys_rst_i = 1'b0;
      {esr_m, pd1_m, pd3_m} = {ESR_RST, PD1_RST, PD3_RST};
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      sys_rst_i = 1'b1;
      {esr_wr_i, pd1_wr_i, pd3_wr_i} = 3'h0;
      {esr_wdata_i, pd1_wdata_i, pd3_wdata_i} = '0;
      drv = '0;
      drv_en = '1;
      po = '{default: '0};
      pe = '{default: '0};
      void'($urandom(32'hC632A8F5));
      repeat (16) @(posedge ref_clk_i);
      #1;
      reset_check();
      shake();
      settle();
      verify();
      // Parallel 1..7 crossed with both serial fields
      for (int i = 0; i < 112; i++) begin
         e = 16'($urandom());
         e[14:12] = 3'(1 + i % 7);
         e[11:8] = 4'(i / 7);
         shake();
         wr_cfg(e, 12'($urandom()), 16'($urandom()), 1'b0);
         settle();
         verify();
      end
      wr_cfg(16'h2155, 12'hA5A, 16'h5A5A, 1'b1);
      wr_cfg(16'h6AAA, 12'h5A5, 16'hA5A7, 1'b0);
      settle();
      verify();
      sys_rst_i = 1'b1;
      settle();
      reset_check();
      settle();
      verify();
      results();
   end

   initial begin
      repeat (5000) @(posedge ref_clk_i);
      fails++;
      results();
   end
endmodule // tb_serial_port_pin_multiplexer

bind sppm_top sppm_checker sppm_checker_i (.*);
